// file: core/cs_unit_params.svh
`ifndef CS_UNIT_PARAMS_SVH
`define CS_UNIT_PARAMS_SVH

// ----------------------------------------
// register map, word writes in I/O space
// ----------------------------------------
`define CSU_ADDR_UPPER 16'hffa0
`define CSU_ADDR_LOWER 16'hffa2
`define CSU_ADDR_PBASE 16'hffa4
`define CSU_ADDR_MIDDLE 16'hffa6
`define CSU_ADDR_PMODE 16'hffa8
`define CSU_REG_PAGE 8'hff

// ----------------------------------------
// reset values
// ----------------------------------------
`define CSU_RST_UPPER 16'h0003
`define CSU_RST_LOWER 16'h0003
`define CSU_RST_PBASE 16'h0007
`define CSU_RST_MIDDLE 16'h8001
`define CSU_RST_PMODE 16'h0007

// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define CSU_MEM_WAIT_MSB 1
`define CSU_LOWER_MASK 16'h0003
`define CSU_UPPER_MASK 16'h0003
`define CSU_PBASE_MASK 16'hff07
`define CSU_MIDDLE_MASK 16'hff01
`define CSU_PMODE_MASK 16'h000f
`define CSU_PWAIT_MSB 2
`define CSU_PAGE_LSB 8
`define CSU_MIDDLE_EN_BIT 0
`define CSU_PMODE_SEL_BIT 0
`define CSU_PMODE_WAIT_LSB 1

// ----------------------------------------
// address map
// ----------------------------------------
`define CSU_UPPER_BIT 19
`define CSU_MIDDLE_SIZE 20'h40000
`define CSU_PERIPH_COUNT 7
`define CSU_PCS_LOW_GROUP 5

// ----------------------------------------
// timing
// ----------------------------------------
`define CSU_CLK_PERIOD_NS 20
`define CSU_STROBE_BASE_NS 100
`define CSU_WAIT_STEP_NS 25

`endif

// file: core/cs_unit_pkg.sv
package cs_unit_pkg;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_HOLD = 1'b1
  } csu_state_t;

  typedef logic [4:0] cyc_count_t;
  typedef logic [3:0] wait_count_t;
endpackage

// file: core/wait_state_counter.sv
`timescale 1ns/100ps
`include "cs_unit_params.svh"

module wait_state_counter
  import cs_unit_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire cyc_count_t loadCount,
  output logic busy,
  output logic expire
);
  cyc_count_t count_r;
  cyc_count_t count_nxt;

  // load on select assertion, count down, expire on the last held cycle
  assign count_nxt = load ? loadCount : (busy ? count_r - 5'h01 : count_r);
  assign busy = (count_r != 5'h00);
  assign expire = (count_r == 5'h01);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= 5'h00;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule

// file: core/select_decoder.sv
`timescale 1ns/100ps
`include "cs_unit_params.svh"

module select_decoder
  import cs_unit_pkg::*;
#(
  parameter int PERIPH_COUNT = `CSU_PERIPH_COUNT
) (
  input wire logic isIo,
  input wire logic [19:0] memAddr,
  input wire logic [15:0] ioAddr,
  input wire logic [15:0] pbaseCfg,
  input wire logic [15:0] middleCfg,
  input wire logic [15:0] pmodeCfg,
  output logic upperHit,
  output logic lowerHit,
  output logic middleHit,
  output logic regHit,
  output logic [PERIPH_COUNT-1:0] periphHit
);
  logic [7:0] pageDelta;
  logic [19:0] middleBase;
  logic [19:0] middleOff;
  logic [PERIPH_COUNT-1:0] periphOne;

  // memory and I/O spaces never overlap in decode
  assign upperHit = !isIo && memAddr[`CSU_UPPER_BIT];
  assign lowerHit = !isIo && !memAddr[`CSU_UPPER_BIT];
  assign middleBase = {middleCfg[15:`CSU_PAGE_LSB], 12'h000};
  assign middleOff = memAddr - middleBase;
  assign middleHit = !isIo && middleCfg[`CSU_MIDDLE_EN_BIT] &&
                     (memAddr >= middleBase) && (middleOff < `CSU_MIDDLE_SIZE);
  assign regHit = isIo && (ioAddr[15:`CSU_PAGE_LSB] == `CSU_REG_PAGE);
  // one select per 0x100 page above the programmed base
  assign pageDelta = ioAddr[15:`CSU_PAGE_LSB] - pbaseCfg[15:`CSU_PAGE_LSB];
  assign periphOne = (pageDelta < 8'(PERIPH_COUNT)) ?
                     PERIPH_COUNT'(1) << pageDelta[2:0] : '0;
  // five and six only act as selects when the mode bit says so
  assign periphHit = (isIo && !regHit) ?
                     (periphOne & ~(pmodeCfg[`CSU_PMODE_SEL_BIT] ? '0 :
                     PERIPH_COUNT'(7'h60))) : '0;
endmodule

// file: core/chip_select_wait_state_unit.sv
`timescale 1ns/100ps
`include "cs_unit_params.svh"

module chip_select_wait_state_unit
  import cs_unit_pkg::*;
#(
  parameter int PERIPH_COUNT = `CSU_PERIPH_COUNT
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cycleStart,
  input wire logic cycleIsIo,
  input wire logic cycleWrite,
  input wire logic cycleWord,
  input wire logic [15:0] segment,
  input wire logic [15:0] offset,
  input wire logic [15:0] ioAddr,
  input wire logic [15:0] wrData,
  output logic upper_memory_select_b,
  output logic lower_memory_select_b,
  output logic first_middle_memory_select_b,
  output logic [PERIPH_COUNT-1:0] peripheral_selects_b,
  output logic ioStrobe,
  output logic cycleDone,
  output logic [15:0] rdData
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic wait_count_t waitFromCode(input logic [2:0] code);
    unique case (code)
      3'h4: waitFromCode = 4'h5;
      3'h5: waitFromCode = 4'h7;
      3'h6: waitFromCode = 4'h9;
      3'h7: waitFromCode = 4'hf;
      default: waitFromCode = {1'b0, code};
    endcase
  endfunction

  // least time rounds up to whole clocks, so 25 ns steps never shorten
  function automatic cyc_count_t strobeCycles(input wait_count_t waits);
    int ns;
    ns = `CSU_STROBE_BASE_NS + `CSU_WAIT_STEP_NS * int'(waits);
    strobeCycles = cyc_count_t'((ns + `CSU_CLK_PERIOD_NS - 1) / `CSU_CLK_PERIOD_NS);
  endfunction

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [15:0] upperCfg_r;
  logic [15:0] lowerCfg_r;
  logic [15:0] pbaseCfg_r;
  logic [15:0] middleCfg_r;
  logic [15:0] pmodeCfg_r;
  csu_state_t state_r;
  csu_state_t state_nxt;
  logic upperSelB_r;
  logic lowerSelB_r;
  logic middleSelB_r;
  logic [PERIPH_COUNT-1:0] periphSelB_r;
  logic ioStrobe_r;
  logic cycleDone_r;
  logic [15:0] rdData_r;
  logic upperSelB_nxt;
  logic lowerSelB_nxt;
  logic middleSelB_nxt;
  logic [PERIPH_COUNT-1:0] periphSelB_nxt;
  logic ioStrobe_nxt;
  logic cycleDone_nxt;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic [19:0] memAddr;
  logic upperHit;
  logic lowerHit;
  logic middleHit;
  logic regHit;
  logic [PERIPH_COUNT-1:0] periphHit;
  logic highGroup;
  logic anyPeriph;
  logic anyMem;
  logic accept;
  logic regAccess;
  logic wordWrite;
  wait_count_t upperWaits;
  wait_count_t lowerWaits;
  wait_count_t periphWaits;
  wait_count_t cycleWaits;
  cyc_count_t loadCount;
  logic loadCounter;
  logic counterBusy;
  logic counterExpire;
  logic [15:0] regRead;
  logic atUpper;
  logic atLower;
  logic atPbase;
  logic atMiddle;
  logic atPmode;
  logic wrUpper;
  logic wrLower;
  logic wrPbase;
  logic wrMiddle;
  logic wrPmode;

  assign memAddr = {segment, 4'h0} + {4'h0, offset};

  select_decoder #(
    .PERIPH_COUNT(PERIPH_COUNT)
  ) decoder (
    .isIo(cycleIsIo),
    .memAddr(memAddr),
    .ioAddr(ioAddr),
    .pbaseCfg(pbaseCfg_r),
    .middleCfg(middleCfg_r),
    .pmodeCfg(pmodeCfg_r),
    .upperHit(upperHit),
    .lowerHit(lowerHit),
    .middleHit(middleHit),
    .regHit(regHit),
    .periphHit(periphHit)
  );

  assign accept = cycleStart && (state_r == ST_IDLE) && !counterBusy;
  assign regAccess = accept && regHit;
  // byte writes to the control block are dropped, the master must use words
  assign wordWrite = regAccess && cycleWrite && cycleWord;
  assign anyPeriph = |periphHit;
  assign anyMem = !cycleIsIo;
  assign highGroup = |periphHit[PERIPH_COUNT-1:`CSU_PCS_LOW_GROUP];

  assign upperWaits = {2'h0, upperCfg_r[`CSU_MEM_WAIT_MSB:0]};
  // lower cycles never sample a ready input; pseudo-static mode is absent
  assign lowerWaits = {2'h0, lowerCfg_r[`CSU_MEM_WAIT_MSB:0]};
  assign periphWaits = highGroup ?
    waitFromCode(pmodeCfg_r[`CSU_PMODE_WAIT_LSB +: 3]) :
    waitFromCode(pbaseCfg_r[`CSU_PWAIT_MSB:0]);
  assign cycleWaits = cycleIsIo ? periphWaits : (upperHit ? upperWaits : lowerWaits);
  assign loadCount = strobeCycles(cycleWaits);
  assign loadCounter = accept && !regHit && (anyPeriph || anyMem);

  // ----------------------------------------
  // register access
  // ----------------------------------------
  // one compare per register, shared by read mux and write strobes
  assign atUpper = (ioAddr == `CSU_ADDR_UPPER);
  assign atLower = (ioAddr == `CSU_ADDR_LOWER);
  assign atPbase = (ioAddr == `CSU_ADDR_PBASE);
  assign atMiddle = (ioAddr == `CSU_ADDR_MIDDLE);
  assign atPmode = (ioAddr == `CSU_ADDR_PMODE);
  assign wrUpper = wordWrite && atUpper;
  assign wrLower = wordWrite && atLower;
  assign wrPbase = wordWrite && atPbase;
  assign wrMiddle = wordWrite && atMiddle;
  assign wrPmode = wordWrite && atPmode;

  assign regRead = atUpper ? upperCfg_r :
                   atLower ? lowerCfg_r :
                   atPbase ? pbaseCfg_r :
                   atMiddle ? middleCfg_r :
                   atPmode ? pmodeCfg_r : 16'h0000;

  // ----------------------------------------
  // cycle state and next values
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (loadCounter) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (counterExpire) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // selects kept low-true in their flops, so pins come straight off registers
  assign upperSelB_nxt = loadCounter ? !upperHit :
                         (counterExpire ? 1'b1 : upperSelB_r);
  assign lowerSelB_nxt = loadCounter ? !lowerHit :
                         (counterExpire ? 1'b1 : lowerSelB_r);
  assign middleSelB_nxt = loadCounter ? !middleHit :
                          (counterExpire ? 1'b1 : middleSelB_r);
  assign periphSelB_nxt = loadCounter ? ~periphHit :
                          (counterExpire ? '1 : periphSelB_r);
  assign ioStrobe_nxt = loadCounter ? anyPeriph :
                        (counterExpire ? 1'b0 : ioStrobe_r);
  // an I/O cycle that hits nothing still completes; rdData changes only on register-page reads
  assign cycleDone_nxt = counterExpire || (accept && !loadCounter);

  wait_state_counter counter (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(loadCounter),
    .loadCount(loadCount),
    .busy(counterBusy),
    .expire(counterExpire)
  );

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      upperCfg_r <= `CSU_RST_UPPER;
    end else if (wrUpper) begin
      upperCfg_r <= wrData & `CSU_UPPER_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowerCfg_r <= `CSU_RST_LOWER;
    end else if (wrLower) begin
      lowerCfg_r <= wrData & `CSU_LOWER_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pbaseCfg_r <= `CSU_RST_PBASE;
    end else if (wrPbase) begin
      pbaseCfg_r <= wrData & `CSU_PBASE_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      middleCfg_r <= `CSU_RST_MIDDLE;
    end else if (wrMiddle) begin
      middleCfg_r <= wrData & `CSU_MIDDLE_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pmodeCfg_r <= `CSU_RST_PMODE;
    end else if (wrPmode) begin
      pmodeCfg_r <= wrData & `CSU_PMODE_MASK;
    end
  end

  // ----------------------------------------
  // cycle control and selects
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      upperSelB_r <= 1'b1;
      lowerSelB_r <= 1'b1;
      middleSelB_r <= 1'b1;
      periphSelB_r <= '1;
      ioStrobe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      upperSelB_r <= upperSelB_nxt;
      lowerSelB_r <= lowerSelB_nxt;
      middleSelB_r <= middleSelB_nxt;
      periphSelB_r <= periphSelB_nxt;
      ioStrobe_r <= ioStrobe_nxt;
    end
  end

  // ----------------------------------------
  // completion and read data
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cycleDone_r <= 1'b0;
      rdData_r <= 16'h0000;
    end else begin
      cycleDone_r <= cycleDone_nxt;
      if (regAccess && !cycleWrite) begin
        rdData_r <= regRead;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign upper_memory_select_b = upperSelB_r;
  assign lower_memory_select_b = lowerSelB_r;
  assign first_middle_memory_select_b = middleSelB_r;
  assign peripheral_selects_b = periphSelB_r;
  assign ioStrobe = ioStrobe_r;
  assign cycleDone = cycleDone_r;
  assign rdData = rdData_r;
endmodule

// file: sim/cs_unit_properties.sv
`timescale 1ns/100ps
module cs_unit_checker
  import cs_unit_pkg::*;
#(
  parameter int PERIPH_COUNT = 7
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cycleStart,
  input wire logic cycleIsIo,
  input wire logic [15:0] segment,
  input wire logic [15:0] offset,
  input wire logic upper_memory_select_b,
  input wire logic lower_memory_select_b,
  input wire logic first_middle_memory_select_b,
  input wire logic [PERIPH_COUNT-1:0] peripheral_selects_b,
  input wire logic ioStrobe,
  input wire logic cycleDone
);
  // ----
  // helpers
  // ----
  logic [19:0] memAddr;
  logic up, lo, mid, memGo, ioGo;
  logic [4:0] strobeCnt;
  assign memAddr = {segment, 4'h0} + {4'h0, offset};
  assign up = upper_memory_select_b;
  assign lo = lower_memory_select_b;
  assign mid = first_middle_memory_select_b;
  assign memGo = cycleStart & up & lo & mid & (&peripheral_selects_b) & ~cycleIsIo;
  assign ioGo = cycleStart & up & lo & mid & (&peripheral_selects_b) & cycleIsIo;
  // longest strobe is code 7, 24 clocks
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobeCnt <= 5'h0;
    end else begin
      strobeCnt <= ioStrobe ? strobeCnt + 5'h1 : 5'h0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ----
  // properties
  // ----
  a_upper_hit: assert property (memGo & memAddr[19] |=> !up)
    else $error("upper select missed");
  a_lower_hit: assert property (memGo & !memAddr[19] |=> !lo & up)
    else $error("lower select wrong");
  a_middle_win: assert property (memGo & (memAddr[19:18] == 2'h2) |=> !mid)
    else $error("middle window missed");
  a_io_apart: assert property (ioGo |=> up & lo & mid)
    else $error("memory select on io cycle");
  a_lower_len: assert property ($fell(lo) |-> ##8 !lo ##1 (lo & cycleDone))
    else $error("lower select length wrong");
  a_upper_release: assert property ($rose(up) |-> cycleDone)
    else $error("upper release without done");
  a_strobe_sel: assert property (ioStrobe |-> !(&peripheral_selects_b))
    else $error("strobe without select");
  a_strobe_max: assert property (ioStrobe |-> strobeCnt < 5'h18)
    else $error("strobe too long");
endmodule

bind chip_select_wait_state_unit cs_unit_checker #(.PERIPH_COUNT(PERIPH_COUNT)) chk_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .cycleStart(cycleStart), .cycleIsIo(cycleIsIo),
  .segment(segment), .offset(offset), .upper_memory_select_b(upper_memory_select_b),
  .lower_memory_select_b(lower_memory_select_b),
  .first_middle_memory_select_b(first_middle_memory_select_b),
  .peripheral_selects_b(peripheral_selects_b), .ioStrobe(ioStrobe), .cycleDone(cycleDone));

// file: sim/periph_model.sv
`timescale 1ns/100ps
module periph_model
  import cs_unit_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [9:0] selects_b,
  output logic [4:0] lowCount
);
  // ----
  // access length seen by the load
  // ----
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCount <= 5'h0;
    end else if (&selects_b) begin
      lowCount <= 5'h0;
    end else begin
      lowCount <= lowCount + 5'h1;
    end
  end
endmodule

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench
  import cs_unit_pkg::*;
;
  typedef struct {logic [9:0] sel; logic [4:0] n; logic [15:0] rd; logic rc;} note_t;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cycleStart = 1'b0, cycleIsIo = 1'b0, cycleWrite = 1'b0, cycleWord = 1'b0;
  logic [15:0] segment = 16'h0, offset = 16'h0, wrData = 16'h0, rdData;
  logic upSel, loSel, midSel, ioStrobe, cycleDone;
  logic [6:0] pSel;
  logic [4:0] lowCount;
  logic [9:0] selVec, selAcc = 10'h3ff;
  logic [31:0] seed = 32'h58d7;
  note_t e;
  note_t notes[$];
  int fail_count = 0, n_tests = 0;
  assign selVec = {upSel, loSel, midSel, pSel};
  always #10 sys_clk = ~sys_clk;
  chip_select_wait_state_unit chip_select_wait_state_unit_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .cycleStart(cycleStart), .cycleIsIo(cycleIsIo), .cycleWrite(cycleWrite),
    .cycleWord(cycleWord), .segment(segment), .offset(offset), .ioAddr(offset),
    .wrData(wrData), .upper_memory_select_b(upSel), .lower_memory_select_b(loSel),
    .first_middle_memory_select_b(midSel), .peripheral_selects_b(pSel),
    .ioStrobe(ioStrobe), .cycleDone(cycleDone), .rdData(rdData));
  periph_model periph_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .selects_b(selVec),
    .lowCount(lowCount));
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  // strobe rounds up to whole clocks
  function automatic logic [4:0] nOf(input int w);
    return 5'((119 + 25 * w) / 20);
  endfunction
  function automatic int wmap(input int c);
    return (c < 4) ? c : ((c == 7) ? 15 : 2 * c - 3);
  endfunction
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----
  // driver: ctl is io, write, word
  // ----
  task automatic bus(input logic [2:0] ctl, input logic [15:0] sg, input logic [15:0] of,
    input logic [15:0] d, input logic [9:0] s, input logic [4:0] n, input logic [15:0] r);
    int k;
    @(posedge sys_clk);
    #2;
    {cycleIsIo, cycleWrite, cycleWord} = ctl;
    segment = sg;
    offset = of;
    wrData = d;
    cycleStart = 1'b1;
    notes.push_back('{s, n, r, (ctl == 3'h5) && (s == 10'h3ff)});
    @(posedge sys_clk);
    #2;
    cycleStart = 1'b0;
    for (k = 0; k < 40 && cycleDone !== 1'b1; k++) begin
      @(negedge sys_clk);
    end
    if (cycleDone !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic rg(input logic [1:0] ww, input logic [15:0] a, input logic [15:0] d,
    input logic [15:0] r);
    bus({1'b1, ww}, 16'h0, a, d, 10'h3ff, 5'h0, r);
  endtask
  // ----
  // monitor
  // ----
  always @(negedge sys_clk) begin
    if (cycleDone === 1'b1 && notes.size() > 0) begin
      e = notes.pop_front();
      chk("selects", {6'h0, e.sel}, {6'h0, selAcc});
      chk("sel_cycles", {11'h0, e.n}, {11'h0, lowCount});
      if (e.rc) begin
        chk("rdData", e.rd, rdData);
      end
      selAcc = 10'h3ff;
    end else begin
      selAcc = selAcc & selVec;
    end
  end
  initial begin
    logic [15:0] sg, of;
    logic [19:0] a;
    logic [15:0] rv[5];
    rv = '{16'h0003, 16'h0003, 16'h0007, 16'h8001, 16'h0007};
    repeat (2) @(posedge sys_clk);
    #2;
    rst_b = 1'b1;
    for (int k = 0; k < 5; k++) begin
      rg(2'h1, 16'hffa0 + 16'(2 * k), 16'h0, rv[k]);
    end
    rg(2'h1, 16'hffaa, 16'h0, 16'h0);
    for (int k = 0; k < 6; k++) begin
      sg = rnd();
      sg[15] = k[0];
      of = rnd();
      a = {sg, 4'h0} + {4'h0, of};
      bus(3'h1, sg, of, 16'h0, ~{a[19], ~a[19], a[19:18] == 2'h2, 7'h0}, 5'h9, 16'h0);
    end
    for (int k = 0; k < 7; k++) begin
      bus(3'h5, 16'h0, {8'(k), 8'(rnd())}, 16'h0, ~{3'h0, 7'(1 << k)},
        nOf(k < 5 ? 15 : 3), 16'h0);
    end
    for (int k = 0; k < 8; k++) begin
      rg(2'h3, 16'hffa4, 16'(k), 16'h0);
      bus(3'h7, 16'h0, {8'h02, 8'(rnd())}, 16'h0, 10'h3fb, nOf(wmap(k)), 16'h0);
    end
    rg(2'h2, 16'hffa0, 16'h0, 16'h0);
    rg(2'h1, 16'hffa0, 16'h0, 16'h0003);
    rg(2'h3, 16'hffa0, 16'h0, 16'h0);
    rg(2'h1, 16'hffa0, 16'h0, 16'h0);
    bus(3'h1, 16'hf000, 16'h0, 16'h0, 10'h1ff, nOf(0), 16'h0);
    bus(3'h7, 16'h0, 16'h8012, 16'h5a5a, 10'h3ff, 5'h0, 16'h0);
    // let the monitor take the last note before judging
    repeat (2) @(posedge sys_clk);
    chk("notes_left", 16'h0, 16'(notes.size()));
    print_verdict();
  end
endmodule
